// ==== design/packet_buffer_ram.sv ====
`timescale 1ns/1ps
module packet_buffer_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 1024,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic writeEn,
    input wire logic [AW-1:0] writeAddr,
    input wire logic [WIDTH-1:0] writeData,
    input wire logic [AW-1:0] readAddr,
    output logic [WIDTH-1:0] readData
);
    logic [WIDTH-1:0] mem [DEPTH];

    if (DEPTH < 2) begin : g_depth_check
        $error("packet_buffer_ram: DEPTH too small");
    end

    always_ff @(posedge clk) begin
        if (writeEn) begin
            mem[writeAddr] <= writeData;
        end
        readData <= mem[readAddr];
    end
endmodule // packet_buffer_ram

// ==== design/serial_packet_packer.sv ====
`timescale 1ns/1ps
`include "packer_defines.svh"
module serial_packet_packer #(
    parameter int DEPTH = `BUF_DEPTH,
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial receive side
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    output logic rxReady,
    // Network transmit side
    output logic txValid,
    output packer_pkg::beat_t txBeat,
    input wire logic txReady
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH != 1024 || TICK_CYCLES < 1) begin : g_param_check
        $error("serial_packet_packer: unsupported parameters");
    end

    // ----------------------------------------------------------------
    // Register interface
    // ----------------------------------------------------------------
    packer_pkg::cfg_t cfg, next_cfg;
    logic awHeld, next_awHeld, wHeld, next_wHeld;
    logic [7:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData;
    logic [3:0] wStrb, next_wStrb;
    logic bValid, next_bValid;
    logic [1:0] bResp, next_bResp;
    logic rValid, next_rValid;
    logic [1:0] rResp, next_rResp;
    logic [31:0] rData, next_rData;
    logic [10:0] count;
    logic [31:0] packetsSent;
    logic sending;

    assign s_axi_awready = !awHeld && !bValid;
    assign s_axi_wready = !wHeld && !bValid;
    assign s_axi_bvalid = bValid;
    assign s_axi_bresp = bResp;
    assign s_axi_arready = !rValid;
    assign s_axi_rvalid = rValid;
    assign s_axi_rresp = rResp;
    assign s_axi_rdata = rData;

    always_comb begin
        next_cfg = cfg;
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddr = awAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bValid = bValid;
        next_bResp = bResp;
        next_rValid = rValid;
        next_rResp = rResp;
        next_rData = rData;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (awHeld && wHeld) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bValid = 1'b1;
            next_bResp = `RESP_OKAY;
            unique case ({awAddr[7:2], 2'b00})
                `REG_LENGTH: begin
                    if (wStrb[0]) next_cfg.lengthLimit[7:0] = wData[7:0];
                    if (wStrb[1]) next_cfg.lengthLimit[10:8] = wData[10:8];
                end
                `REG_DELIM: begin // R3
                    if (wStrb[0]) next_cfg.delim1Char = wData[`DELIM1_CHAR_LSB +: 8];
                    if (wStrb[1]) next_cfg.delim2Char = wData[`DELIM2_CHAR_LSB +: 8];
                    if (wStrb[2]) begin
                        next_cfg.delim1En = wData[`DELIM1_EN_BIT];
                        next_cfg.delim2En = wData[`DELIM2_EN_BIT];
                        next_cfg.proc = packer_pkg::proc_t'(wData[`PROC_LSB +: 2]);
                    end
                end
                `REG_IDLE: begin
                    if (wStrb[0]) next_cfg.idleMs[7:0] = wData[7:0];
                    if (wStrb[1]) next_cfg.idleMs[15:8] = wData[15:8];
                end
                `REG_STATUS: ;
                default: next_bResp = `RESP_SLVERR;
            endcase
        end else if (bValid && s_axi_bready) begin
            next_bValid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rValid = 1'b1;
            next_rResp = `RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                `REG_LENGTH: next_rData = {21'h000000, cfg.lengthLimit};
                `REG_DELIM: next_rData = {12'h000, cfg.proc, cfg.delim2En, cfg.delim1En,
                    cfg.delim2Char, cfg.delim1Char};
                `REG_IDLE: next_rData = {16'h0000, cfg.idleMs};
                `REG_STATUS: next_rData = {packetsSent[19:0], sending, count};
                default: begin
                    next_rData = 32'h00000000;
                    next_rResp = `RESP_SLVERR;
                end
            endcase
        end else if (rValid && s_axi_rready) begin
            next_rValid = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg <= '{lengthLimit: `LENGTH_RESET, delim1En: 1'b0, delim2En: 1'b0,
                delim1Char: 8'h00, delim2Char: 8'h00, proc: packer_pkg::PROC_PASS,
                idleMs: `IDLE_RESET};
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 8'h00;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
            bValid <= 1'b0;
            bResp <= 2'h0;
            rValid <= 1'b0;
            rResp <= 2'h0;
            rData <= 32'h00000000;
        end else begin
            cfg <= next_cfg;
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            bValid <= next_bValid;
            bResp <= next_bResp;
            rValid <= next_rValid;
            rResp <= next_rResp;
            rData <= next_rData;
        end
    end

    // ----------------------------------------------------------------
    // Millisecond tick and idle timer
    // ----------------------------------------------------------------
    logic [31:0] tickCnt, next_tickCnt;
    logic [15:0] idleCnt, next_idleCnt;
    logic tick;
    logic rxTake;
    assign tick = (tickCnt == 32'(TICK_CYCLES - 1));
    assign rxTake = rxValid && rxReady;

    always_comb begin
        next_tickCnt = tick ? 32'h00000000 : tickCnt + 32'h00000001; // R15
        next_idleCnt = idleCnt;
        if (rxTake || count == 11'h000) begin
            next_idleCnt = 16'h0000; // R15
        end else if (tick && idleCnt != 16'hFFFF) begin
            next_idleCnt = idleCnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tickCnt <= 32'h00000000;
            idleCnt <= 16'h0000;
        end else begin
            tickCnt <= next_tickCnt;
            idleCnt <= next_idleCnt;
        end
    end

    // ----------------------------------------------------------------
    // Packing decision
    // ----------------------------------------------------------------
    logic [7:0] prevByte, next_prevByte;
    logic prevValid, next_prevValid;
    logic [1:0] tailLeft, next_tailLeft;
    logic tailActive, next_tailActive;
    logic [10:0] next_count, sendLen, next_sendLen, sendIdx, next_sendIdx;
    logic next_sending;
    logic [31:0] next_packetsSent;
    logic match, flush, lengthHit, fullHit, idleHit, delimOn;
    logic [10:0] countInc, stripLen;

    assign delimOn = cfg.delim1En; // R6
    // Single character, or first immediately followed by second
    assign match = delimOn && (cfg.delim2En ? // R4
        (prevValid && prevByte == cfg.delim1Char && rxData == cfg.delim2Char) :
        (rxData == cfg.delim1Char));
    assign countInc = count + 11'h001;
    assign lengthHit = rxTake && cfg.lengthLimit != 11'h000 && countInc == cfg.lengthLimit; // R1 R2
    assign fullHit = rxTake && countInc == 11'(DEPTH); // R5
    // Silence only counts while bytes wait; zero disables it
    assign idleHit = !rxTake && cfg.idleMs != 16'h0000 && count != 11'h000
        && idleCnt >= cfg.idleMs; // R11 R12
    assign stripLen = countInc - (cfg.delim2En ? 11'h002 : 11'h001); // R10
    assign rxReady = !sending;

    always_comb begin
        next_prevByte = prevByte;
        next_prevValid = prevValid;
        next_tailLeft = tailLeft;
        next_tailActive = tailActive;
        next_count = count;
        next_sending = sending;
        next_sendLen = sendLen;
        next_sendIdx = sendIdx;
        next_packetsSent = packetsSent;
        flush = 1'b0;
        if (rxTake) begin
            next_count = countInc;
            next_prevByte = rxData;
            next_prevValid = 1'b1;
            next_sendLen = countInc;
            if (tailActive) begin
                next_tailLeft = tailLeft - 2'h1;
                if (tailLeft == 2'h1) flush = 1'b1; // R8 R9
            end else if (match) begin
                unique case (cfg.proc)
                    packer_pkg::PROC_PASS: flush = 1'b1; // R7
                    packer_pkg::PROC_PLUS1: begin
                        next_tailActive = 1'b1;
                        next_tailLeft = 2'h1; // R8
                    end
                    packer_pkg::PROC_PLUS2: begin
                        next_tailActive = 1'b1;
                        next_tailLeft = 2'h2; // R9
                    end
                    packer_pkg::PROC_STRIP: begin
                        flush = 1'b1;
                        next_sendLen = stripLen; // R10
                    end
                endcase
            end
            if (lengthHit || fullHit) flush = 1'b1; // R2 R5
        end else if (idleHit) begin
            flush = 1'b1; // R12
            next_sendLen = count;
        end
        if (flush) begin
            // One packet, every piece of match state cleared
            next_count = 11'h000; // R16
            next_prevValid = 1'b0;
            next_tailActive = 1'b0;
            next_tailLeft = 2'h0;
            next_sendIdx = 11'h000;
            next_sending = next_sendLen != 11'h000;
            next_packetsSent = packetsSent + 32'h00000001;
        end
        if (sending && (!txValid || txReady)) begin
            next_sendIdx = sendIdx + 11'h001;
            if (sendIdx == sendLen) next_sending = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prevByte <= 8'h00;
            prevValid <= 1'b0;
            tailLeft <= 2'h0;
            tailActive <= 1'b0;
            count <= 11'h000;
            sending <= 1'b0;
            sendLen <= 11'h000;
            sendIdx <= 11'h000;
            packetsSent <= 32'h00000000;
        end else begin
            prevByte <= next_prevByte;
            prevValid <= next_prevValid;
            tailLeft <= next_tailLeft;
            tailActive <= next_tailActive;
            count <= next_count;
            sending <= next_sending;
            sendLen <= next_sendLen;
            sendIdx <= next_sendIdx;
            packetsSent <= next_packetsSent;
        end
    end

    // ----------------------------------------------------------------
    // Buffer and transmit stream
    // ----------------------------------------------------------------
    // Intake stalls while a packet drains; trades throughput for one buffer
    logic [7:0] ramData;
    logic txValidR, next_txValid, txLast, next_txLast;
    // The index runs one ahead of the shown beat, so a stall re-reads its word
    logic [10:0] readIdx;
    assign readIdx = (txValidR && !txReady) ? sendIdx - 11'h001 : sendIdx;

    packet_buffer_ram #(.WIDTH(8), .DEPTH(DEPTH)) buffer (
        .clk(clk),
        .writeEn(rxTake),
        .writeAddr(count[AW-1:0]),
        .writeData(rxData),
        .readAddr(readIdx[AW-1:0]),
        .readData(ramData)
    );

    always_comb begin
        next_txValid = txValidR;
        next_txLast = txLast;
        if (txValidR && txReady) next_txValid = 1'b0;
        if (sending && (!txValidR || txReady) && sendIdx != sendLen) begin
            next_txValid = 1'b1;
            next_txLast = (sendIdx + 11'h001 == sendLen);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txValidR <= 1'b0;
            txLast <= 1'b0;
        end else begin
            txValidR <= next_txValid;
            txLast <= next_txLast;
        end
    end

    assign txValid = txValidR;
    assign txBeat = '{data: ramData, last: txLast};
endmodule // serial_packet_packer

// ==== dv/network_sink_model.sv ====
`timescale 1ns/1ps
module network_sink_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic stall,
    output logic txReady
);
    logic [1:0] phase;
    // Slow mode takes one beat in four, so a beat waits up to three cycles
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) phase <= 2'h0;
        else phase <= phase + 2'h1;
    end
    assign txReady = !stall || (phase == 2'h3);
endmodule // network_sink_model

// ==== dv/packer_monitor.sv ====
`timescale 1ns/1ps
module packer_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rxReady,
    input wire logic txValid,
    input wire packer_pkg::beat_t txBeat,
    input wire logic txReady
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ----------------------------------------
    // Network side
    // ----------------------------------------
    property p_txHold;
        txValid && !txReady |=> txValid && $stable(txBeat);
    endproperty
    a_txHold: assert property (p_txHold) else $error("tx beat changed while stalled");
    property p_lastEnds;
        txValid && txReady && txBeat.last |=> !txValid;
    endproperty
    a_lastEnds: assert property (p_lastEnds) else $error("beat after last");
    property p_drainBlocks;
        txValid |-> !rxReady;
    endproperty
    a_drainBlocks: assert property (p_drainBlocks) else $error("serial taken in drain");
    property p_firstBeat;
        $rose(txValid) |-> $past(!rxReady);
    endproperty
    a_firstBeat: assert property (p_firstBeat) else $error("beat without flush");
    property p_rxResume;
        txValid && txReady && txBeat.last |-> ##[1:3] rxReady;
    endproperty
    a_rxResume: assert property (p_rxResume) else $error("serial side not resumed");

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    property p_bOnce;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bOnce: assert property (p_bOnce) else $error("second write response");
    property p_rOnce;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rOnce: assert property (p_rOnce) else $error("second read response");
    property p_awBlock;
        s_axi_bvalid |-> !s_axi_awready;
    endproperty
    a_awBlock: assert property (p_awBlock) else $error("write address taken early");
    property p_arBlock;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_arBlock: assert property (p_arBlock) else $error("read address taken early");
endmodule // packer_monitor

bind serial_packet_packer packer_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rxReady(rxReady), .txValid(txValid), .txBeat(txBeat), .txReady(txReady));

// ==== dv/serial_packet_packer_bench.sv ====
`timescale 1ns/1ps
`include "packer_defines.svh"
module serial_packet_packer_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rxData = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rxValid = 1'b0, stall = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic rxReady, txValid, txReady;
    packer_pkg::beat_t txBeat;
    packer_pkg::beat_t expq[$];
    logic [7:0] stim[$];
    logic [31:0] lfsr = 32'h7BBD1C69;
    int mismatches = 0, samples_checked = 0;

    always #4 clk = ~clk;

    serial_packet_packer #(.TICK_CYCLES(10)) u_dut (.clk(clk), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
        .txValid(txValid), .txBeat(txBeat), .txReady(txReady));
    network_sink_model u_sink (.clk(clk), .sys_rst(sys_rst), .stall(stall),
        .txReady(txReady));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task fail(input string what, input logic [31:0] e, input logic [31:0] s);
        mismatches++;
        $display("unexpected %s expected %h seen %h", what, e, s);
    endtask
    task check(input string what, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) fail(what, e, s);
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task push(input logic [7:0] v, input logic keep, input logic last);
        stim.push_back(v);
        if (keep) expq.push_back({v, last});
    endtask
    function automatic logic [31:0] lfsrNext(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Payload kept in 0x40..0x7F so it never hits a delimiter
    task body(input int n, input int plen);
        for (int i = 0; i < n; i++) begin
            lfsr = lfsrNext(lfsr);
            push({2'b01, lfsr[5:0]}, 1'b1, ((i + 1) % plen) == 0);
        end
    endtask
    task sendAll;
        while (stim.size() != 0) begin
            rxValid <= 1'b1;
            rxData <= stim[0];
            do @(posedge clk); while (!rxReady);
            void'(stim.pop_front());
        end
        rxValid <= 1'b0;
        rxData <= ~rxData;
        @(posedge clk);
    endtask
    task axiWrite(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check("bresp", {30'h0, `RESP_OKAY}, {30'h0, s_axi_bresp});
        @(posedge clk);
    endtask
    task axiRead(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check("rdata", e, s_axi_rdata);
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        @(posedge clk);
    endtask
    task setCfg(input logic [10:0] len, input logic [19:0] dl, input logic [15:0] idle);
        axiWrite(`REG_LENGTH, {21'h0, len});
        axiWrite(`REG_DELIM, {12'h0, dl});
        axiWrite(`REG_IDLE, {16'h0, idle});
    endtask
    task endTest(input string name);
        int n;
        n = 0;
        sendAll;
        while (expq.size() != 0 && n < 8000) begin
            @(posedge clk);
            n++;
        end
        if (expq.size() != 0) fail("pending beats", 32'h0, 32'(expq.size()));
        $display("test %s done", name);
    endtask

    // ----------------------------------------
    // Output scoreboard and watchdog
    // ----------------------------------------
    always @(posedge clk) begin
        if (!sys_rst && txValid && txReady) begin
            if (expq.size() == 0) begin
                fail("tx beat", 32'h0, {23'h0, txBeat});
            end else begin
                samples_checked++;
                if (txBeat !== expq[0]) fail("tx beat", {23'h0, expq[0]}, {23'h0, txBeat});
                void'(expq.pop_front());
            end
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        summarize;
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        stall <= 1'b1;
        setCfg(11'd4, 20'h0, 16'h0);
        axiRead(`REG_LENGTH, 32'h4, `RESP_OKAY);
        axiRead(8'h10, 32'h0, `RESP_SLVERR);
        body(8, 4);
        endTest("length");
        for (int p = 0; p < 4; p++) begin
            setCfg(11'd0, {p[1:0], 2'b01, 8'h00, 8'h0D}, 16'h0);
            axiRead(`REG_DELIM, {12'h0, p[1:0], 2'b01, 16'h000D}, `RESP_OKAY);
            body(2, 9999);
            push(8'h0D, p != 3, p == 0);
            if (p == 3) expq[expq.size() - 1].last = 1'b1;
            if (p == 1 || p == 2) body(p, p);
            endTest("delimiter process");
        end
        setCfg(11'd0, {2'b00, 2'b11, 8'hFF, 8'h00}, 16'h0);
        push(8'h00, 1'b1, 1'b0);
        push(8'h41, 1'b1, 1'b0);
        push(8'h00, 1'b1, 1'b0);
        push(8'hFF, 1'b1, 1'b1);
        endTest("two char");
        setCfg(11'd3, {2'b11, 2'b00, 8'h00, 8'h0D}, 16'h0);
        push(8'h0D, 1'b1, 1'b0);
        body(2, 2);
        endTest("process ignored");
        setCfg(11'd3, {2'b00, 2'b01, 8'h00, 8'h0D}, 16'h0);
        body(2, 9999);
        push(8'h0D, 1'b1, 1'b1);
        body(3, 3);
        endTest("coincident");
        setCfg(11'd0, 20'h0, 16'd3);
        body(1, 9999);
        sendAll;
        repeat (12) @(posedge clk);
        body(1, 1);
        sendAll;
        repeat (12) @(posedge clk);
        check("idle restart", 32'd2, 32'(expq.size()));
        endTest("idle restart");
        body(2, 2);
        endTest("idle flush");
        setCfg(11'd0, 20'h0, 16'd0);
        body(2, 9999);
        sendAll;
        repeat (300) @(posedge clk);
        axiRead(`REG_STATUS, {20'd12, 1'b0, 11'd2}, `RESP_OKAY);
        setCfg(11'd3, 20'h0, 16'd0);
        body(1, 1);
        endTest("idle off");
        setCfg(11'd0, {2'b00, 2'b01, 8'h00, 8'h0D}, 16'h0);
        body(1024, 1024);
        endTest("full buffer");
        summarize;
    end
endmodule // serial_packet_packer_bench

// ==== shared/packer_defines.svh ====
// What this block does
// R1 - Length zero: flush only on delimiter or full
// R2 - Length 1..1024: flush when count equals limit
// R3 - Two delimiters: enable flag plus 8-bit char
// R4 - One char match, or first-then-second sequence
// R5 - Delimiters on: accumulate until full or match
// R6 - Process option ignored when delimiter 1 off
// R7 - Pass-through: flush at match, keep delimiters
// R8 - Plus-one: flush after one more byte
// R9 - Plus-two: flush after two more bytes
// R10 - Strip: flush at match, drop delimiter bytes
// R11 - Idle time zero: never flush on silence
// R12 - Idle time set: flush after that silence
// R13 - Software keeps idle time above one character
// R14 - Software keeps inactivity timeout above idle time
// R15 - Idle timer restarts per byte, millisecond tick
// R16 - Coincident conditions give one packet, full clear
`ifndef PACKER_DEFINES_SVH
`define PACKER_DEFINES_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define REG_LENGTH      8'h00
`define REG_DELIM       8'h04
`define REG_IDLE        8'h08
`define REG_STATUS      8'h0C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DELIM1_CHAR_LSB 0
`define DELIM2_CHAR_LSB 8
`define DELIM1_EN_BIT   16
`define DELIM2_EN_BIT   17
`define PROC_LSB        18
`define LENGTH_RESET    11'h000
`define IDLE_RESET      16'h0000
`define BUF_DEPTH       1024
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ         125
`define TICK_US         1000
`define TICK_CYCLES     (`CLK_MHZ * `TICK_US)

`endif

// ==== shared/packer_pkg.sv ====
package packer_pkg;
    typedef enum logic [1:0] {
        PROC_PASS,
        PROC_PLUS1,
        PROC_PLUS2,
        PROC_STRIP
    } proc_t;

    typedef struct packed {
        logic [10:0] lengthLimit;
        logic        delim1En;
        logic        delim2En;
        logic [7:0]  delim1Char;
        logic [7:0]  delim2Char;
        proc_t       proc;
        logic [15:0] idleMs;
    } cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } beat_t;
endpackage
